// File: hdl/astx_ch78_slot_map.sv
// Overview of operation
// - Channel 7 two-bit source, zero tri-states
// - Ch7 code one sends battery and temperature
// - Ch7 code two sends both echo references
// - Ch8 one-bit source, one sends link data
// - Ch7 slot resets to six
// - Ch8 slot resets to seven
// - Ch7 bit 7 reads zero
// - Ch8 bits 7-6 read zero
`timescale 1ns/1ps

module astx_ch78_slot_map (
    // Clock and reset
    input  wire logic                               clock,
    input  wire logic                               sys_rst,
    // Register port
    input  wire logic [7:0]                         reg_addr,
    input  wire logic                               reg_wr,
    input  wire logic [7:0]                         reg_wdata,
    output logic      [7:0]                         reg_rdata,
    // Frame engine position
    input  wire astx_pkg::astx_fmt_t                frame_format,
    input  wire logic                               slot_start,
    input  wire logic [astx_pkg::SLOT_W-1:0]        slot_index,
    input  wire logic                               right_half,
    // Channel sources
    input  wire logic [astx_pkg::HALF_W-1:0]        battery_voltage_half_word,
    input  wire logic [astx_pkg::HALF_W-1:0]        temperature_half_word,
    input  wire logic [astx_pkg::HALF_W-1:0]        echo_reference_1_half_word,
    input  wire logic [astx_pkg::HALF_W-1:0]        echo_reference_2_half_word,
    input  wire logic [astx_pkg::WORD_W-1:0]        inter_chip_link_aggregation,
    // Slot word to the serialiser
    output logic      [astx_pkg::WORD_W-1:0]        slot_word,
    output logic                                    slot_drive,
    output logic                                    sdout_oe_n
);

    // ********************************
    // Configuration registers
    // ********************************
    logic [1:0]                     ch7_src_reg;
    logic [1:0]                     ch7_src_next;
    logic [astx_pkg::SLOT_W-1:0]    ch7_slot_reg;
    logic [astx_pkg::SLOT_W-1:0]    ch7_slot_next;
    logic                           ch8_src_reg;
    logic                           ch8_src_next;
    logic [astx_pkg::SLOT_W-1:0]    ch8_slot_reg;
    logic [astx_pkg::SLOT_W-1:0]    ch8_slot_next;
    logic [astx_pkg::WORD_W-1:0]    word_reg;
    logic                           drive_reg;
    logic                           drive_next;

    // ********************************
    // Write decode
    // ********************************
    // Only the two addresses of this block are taken; the rest of the
    // map belongs to other channels and is left alone
    wire                            wr7 = reg_wr &&
                                          reg_addr == astx_pkg::CH7_CFG_ADDR;
    wire                            wr8 = reg_wr &&
                                          reg_addr == astx_pkg::CH8_CFG_ADDR;

    // Field slices of the write data; one slot slice serves both
    // channels because the slot field sits at the same place in each
    wire [1:0]                      wd_src7 =
        reg_wdata[astx_pkg::CH7_SRC_MSB:astx_pkg::CH7_SRC_LSB];
    wire                            wd_src8 =
        reg_wdata[astx_pkg::CH8_SRC_BIT];
    wire [astx_pkg::SLOT_W-1:0]     wd_slot =
        reg_wdata[astx_pkg::SLOT_MSB:astx_pkg::SLOT_LSB];

    // Ch8 top bits dropped
    // Reserved bits are never stored, so a careless write cannot leak
    // into the readback
    assign ch7_src_next  = wr7 ? wd_src7 : ch7_src_reg;
    assign ch7_slot_next = wr7 ? wd_slot : ch7_slot_reg;
    assign ch8_src_next  = wr8 ? wd_src8 : ch8_src_reg;
    assign ch8_slot_next = wr8 ? wd_slot : ch8_slot_reg;

    // ********************************
    // Register state
    // ********************************
    // Default slots sit just above the lower channels, so turning a
    // source on without moving its slot avoids those channels
    // Channel 7 source
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ch7_src_reg <= astx_pkg::CH7_CFG_RESET[astx_pkg::CH7_SRC_MSB:
                                                   astx_pkg::CH7_SRC_LSB];
        end else begin
            ch7_src_reg <= ch7_src_next;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ch7_slot_reg <= astx_pkg::CH7_CFG_RESET[astx_pkg::SLOT_MSB:
                                                    astx_pkg::SLOT_LSB];
        end else begin
            ch7_slot_reg <= ch7_slot_next;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ch8_src_reg <= astx_pkg::CH8_CFG_RESET[astx_pkg::CH8_SRC_BIT];
        end else begin
            ch8_src_reg <= ch8_src_next;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ch8_slot_reg <= astx_pkg::CH8_CFG_RESET[astx_pkg::SLOT_MSB:
                                                    astx_pkg::SLOT_LSB];
        end else begin
            ch8_slot_reg <= ch8_slot_next;
        end
    end

    // ********************************
    // Readback
    // ********************************
    // Ch7 reserved zero
    wire [7:0] rd7 = {1'b0, ch7_src_reg, ch7_slot_reg};
    wire [7:0] rd8 = {2'h0, ch8_src_reg, ch8_slot_reg};
    assign reg_rdata = (reg_addr == astx_pkg::CH7_CFG_ADDR) ? rd7 :
                       (reg_addr == astx_pkg::CH8_CFG_ADDR) ? rd8 : 8'h00;

    // ********************************
    // Slot match
    // ********************************
    // Upper bit picks right half in two-channel formats
    wire two_ch = frame_format != astx_pkg::ASTX_FMT_TDM;
    wire [astx_pkg::SLOT_W-1:0] cur_slot = two_ch ?
        {right_half, slot_index[astx_pkg::HALF_SLOT_W-1:0]} : slot_index;

    wire hit7 = cur_slot == ch7_slot_reg;
    wire hit8 = cur_slot == ch8_slot_reg;

    // ********************************
    // Source decode
    // ********************************
    // Reserved code three behaves as off so the line is never fought over
    wire sel_sensor = ch7_src_reg == astx_pkg::ASTX_SRC_SENSOR;
    wire sel_echo   = ch7_src_reg == astx_pkg::ASTX_SRC_ECHO;
    wire on7 = sel_sensor || sel_echo;
    wire on8 = ch8_src_reg;

    // ********************************
    // Slot ownership
    // ********************************
    // A channel owns the slot only when its source is on as well.
    // Overlap with the lower channels is for software to avoid
    wire act7 = hit7 && on7;
    wire act8 = hit8 && on8;

    // ********************************
    // Source words
    // ********************************
    // Half words are packed high first, as the serialiser sends MSB first
    // Battery and temperature word
    wire [astx_pkg::WORD_W-1:0] sens_word =
        {battery_voltage_half_word, temperature_half_word};
    wire [astx_pkg::WORD_W-1:0] echo_word =
        {echo_reference_1_half_word, echo_reference_2_half_word};
    wire [astx_pkg::WORD_W-1:0] link_word = inter_chip_link_aggregation;
    wire [astx_pkg::WORD_W-1:0] ch7_word  = sel_sensor ? sens_word
                                                       : echo_word;

    // ********************************
    // Output selection
    // ********************************
    // Channel 7 wins if both claim one slot; software should avoid it.
    // An idle slot loads zero so stale samples never sit on the bus,
    // and a released slot reads as an all-zero word
    wire [astx_pkg::WORD_W-1:0] word_next = act7 ? ch7_word :
                                            act8 ? link_word : '0;
    assign drive_next = act7 || act8;

    // ********************************
    // Output stage
    // ********************************
    // Word and enable change only at a slot boundary, which gives the
    // serialiser a whole slot to shift the word out.
    // Both share one strobe so they can never disagree
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            word_reg <= '0;
        end else if (slot_start) begin
            word_reg <= word_next;
        end
    end

    // Release the line unless an enabled channel owns the slot
    // Reset leaves the line released until the first slot arrives
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            drive_reg <= 1'b0;
        end else if (slot_start) begin
            drive_reg <= drive_next;
        end
    end

    // The pin driver wants an active-low enable
    assign slot_word  = word_reg;
    assign slot_drive = drive_reg;
    assign sdout_oe_n = ~drive_reg;

endmodule

// File: hdl/astx_pkg.sv
package astx_pkg;

    // ********************************
    // Register map
    // ********************************
    localparam logic [7:0] CH7_CFG_ADDR  = 8'h24;
    localparam logic [7:0] CH8_CFG_ADDR  = 8'h25;
    localparam logic [7:0] CH7_CFG_RESET = 8'h06;
    localparam logic [7:0] CH8_CFG_RESET = 8'h07;

    // ********************************
    // Field layout
    // ********************************
    localparam int SLOT_LSB     = 0;
    localparam int SLOT_MSB     = 4;
    localparam int CH7_SRC_LSB  = 5;
    localparam int CH7_SRC_MSB  = 6;
    localparam int CH8_SRC_BIT  = 5;
    localparam int SLOT_W       = 5;
    localparam int HALF_SLOT_W  = 4;

    // Channel 7 source codes
    typedef enum logic [1:0] {
        ASTX_SRC_OFF    = 2'h0,
        ASTX_SRC_SENSOR = 2'h1,
        ASTX_SRC_ECHO   = 2'h2,
        ASTX_SRC_RSVD   = 2'h3
    } astx_src7_t;

    // Frame format
    typedef enum logic [1:0] {
        ASTX_FMT_TDM = 2'h0,
        ASTX_FMT_I2S = 2'h1,
        ASTX_FMT_LJ  = 2'h2
    } astx_fmt_t;

    // Word length fixed at the widest supported framing
    localparam int WORD_W = 32;
    localparam int HALF_W = 16;

endpackage

// File: tb/astx_checker.sv
`timescale 1ns/1ps
module astx_checker (
    // Clock and reset
    input wire logic        clock,
    input wire logic        sys_rst,
    // Register port
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    // Slot output
    input wire logic        slot_start,
    input wire logic        slot_drive,
    input wire logic        sdout_oe_n,
    input wire logic [31:0] slot_word
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    property p_oe; sdout_oe_n != slot_drive; endproperty
    a_oe: assert property (p_oe) else $error("oe");
    property p_idle; !slot_drive |-> slot_word == 0; endproperty
    a_idle: assert property (p_idle) else $error("idle");
    property p_hold; !slot_start |=> $stable(slot_word); endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_wr;
        reg_wr && reg_addr inside {8'h24, 8'h25} ##1 $stable(reg_addr) |->
            reg_rdata == ($past(reg_wdata) &
                          (reg_addr == 8'h24 ? 8'h7f : 8'h3f));
    endproperty
    a_wr: assert property (p_wr) else $error("write");
    property p_r7; reg_addr == 8'h24 |-> !reg_rdata[7]; endproperty
    a_r7: assert property (p_r7) else $error("bit7");
    property p_r8; reg_addr == 8'h25 |-> reg_rdata[7:6] == 0; endproperty
    a_r8: assert property (p_r8) else $error("bits76");
    property p_d7; $fell(sys_rst) |-> reg_rdata == 8'h06; endproperty
    a_d7: assert property (p_d7) else $error("ch7 reset");
    property p_d8; $fell(sys_rst) |=> reg_rdata == 8'h07; endproperty
    a_d8: assert property (p_d8) else $error("ch8 reset");
    c_on: cover property (slot_start ##1 slot_drive);
    c_off: cover property (slot_start ##1 !slot_drive);
    c_wr: cover property (reg_wr && reg_addr == 8'h25);
endmodule
bind astx_ch78_slot_map astx_checker u_astx_checker (.clock(clock),
    .sys_rst(sys_rst), .reg_wr(reg_wr), .slot_start(slot_start),
    .slot_drive(slot_drive), .sdout_oe_n(sdout_oe_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .slot_word(slot_word));

// File: tb/astx_host_model.sv
`timescale 1ns/1ps
module astx_host_model (
    input  wire logic        clock,
    output logic      [95:0] src = 96'h0
);
    // Fresh words every cycle, so a stale capture cannot pass
    always @(negedge clock) src <= {$urandom, $urandom, $urandom};
endmodule

// File: tb/test_aux_serial_tx_ch7_ch8_slot_map.sv
`timescale 1ns/1ps
module test_aux_serial_tx_ch7_ch8_slot_map;
    logic clock = 0, sys_rst = 1, wr = 0, ss = 0, rh = 0, drv, oe_n, e_on;
    logic [7:0] ad = 8'h24, wd = 0, rd;
    logic [4:0] idx = 0;
    logic [95:0] src;
    logic [31:0] word, e_w;
    astx_pkg::astx_fmt_t fmt = astx_pkg::ASTX_FMT_TDM;
    int n_errors = 0, cmp_count = 0, m7 = 6, m8 = 7, a, k;
    always #10 clock = ~clock;
    astx_host_model u_astx_host_model (.clock(clock), .src(src));
    astx_ch78_slot_map u_astx_ch78_slot_map (.clock(clock), .sys_rst(sys_rst),
        .reg_addr(ad), .reg_wr(wr), .reg_wdata(wd), .reg_rdata(rd),
        .frame_format(fmt), .slot_start(ss), .slot_index(idx),
        .right_half(rh), .battery_voltage_half_word(src[95:80]),
        .temperature_half_word(src[79:64]),
        .echo_reference_1_half_word(src[63:48]),
        .echo_reference_2_half_word(src[47:32]),
        .inter_chip_link_aggregation(src[31:0]), .slot_word(word),
        .slot_drive(drv), .sdout_oe_n(oe_n));
    task chk(input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) n_errors++;
        if (seen !== exp) $display("BAD %0t got %h want %h", $time, seen, exp);
    endtask
    task do_reset;
        sys_rst = 1;
        ad = 8'h24;
        m7 = 6;
        m8 = 7;
        repeat (10) @(negedge clock);
        sys_rst = 0;
        chk(word, 0);
        chk(oe_n, 1);
        chk(rd, 8'h06);
        @(negedge clock) ad = 8'h25;
        @(negedge clock) chk(rd, 8'h07);
    endtask
    task print_verdict;
        $display("%0d compares %0d mismatches", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h38244a89));
        do_reset;
        repeat (400) begin
            a = 8'h24 + $urandom % 3;
            ad = 8'(a);
            wd = 8'($urandom) & (a == 8'h24 ? 8'h7f : 8'h3f);
            wr = 1;
            @(negedge clock) wr = 0;
            if (a == 8'h24) m7 = wd;
            if (a == 8'h25) m8 = wd;
            chk(rd, a == 8'h24 ? m7 : a == 8'h25 ? m8 : 0);
            fmt = astx_pkg::astx_fmt_t'($urandom % 3);
            rh = 1'($urandom);
            // Aim at configured slots so hits are common
            idx = $urandom % 2 ? m7[4:0] : m8[4:0];
            k = fmt == astx_pkg::ASTX_FMT_TDM ? idx : {rh, idx[3:0]};
            ss = 1;
            // Sources change at the falling edge; take them where sampled
            @(posedge clock);
            e_on = 1;
            if (m7[6:5] inside {1, 2} && k == m7[4:0])
                e_w = m7[5] ? src[95:64] : src[63:32];
            else if (m8[5] && k == m8[4:0]) e_w = src[31:0];
            else {e_on, e_w} = 0;
            @(negedge clock) ss = 0;
            chk(word, e_w);
            chk(oe_n, !e_on);
        end
        $display("slot test done");
        do_reset;
        $display("reset test done");
        print_verdict;
    end
endmodule
